//--- rtl/bhm_seq.sv
`timescale 1ns/1ps
`default_nettype none

module bhm_seq
    import bhm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,

    // operation port towards the core
    bhm_if.seq               bus,

    // user request
    input  wire logic        start,
    input  wire logic [1:0]  mode,
    input  wire logic [15:0] operand_a,
    input  wire logic [15:0] operand_b,

    // user answer
    output var  logic        busy,
    output var  logic        done,
    output var  logic [31:0] wide_result_bytes
);

    // ==========================================================
    // sequencer states, one-hot
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_FILE = 7'b0000010,
        S_LDW  = 7'b0000100,
        S_MUL  = 7'b0001000,
        S_WAIT = 7'b0010000,
        S_ACC  = 7'b0100000,
        S_FIX  = 7'b1000000
    } bhm_seq_state_t;

    bhm_seq_state_t state_q;
    logic [1:0]     idx_q;
    logic [15:0]    a_q;
    logic [15:0]    b_q;
    bhm_mode_t      mode_q;
    logic [31:0]    acc_q;
    bhm_op_t        op_q;
    logic [3:0]     addr_q;
    logic [7:0]     wdata_q;

    logic           a_hi_sel;
    logic           b_hi_sel;
    logic [31:0]    partial;
    logic           wide;
    logic           last_part;
    logic [31:0]    fixed;

    // ==========================================================
    // partial product order: ll, hh, lo*hi, hi*lo
    assign a_hi_sel  = (idx_q == 2'd1) || (idx_q == 2'd3);
    assign b_hi_sel  = (idx_q == 2'd1) || (idx_q == 2'd2);
    assign wide      = (mode_q == MODE_U16) || (mode_q == MODE_S16);
    assign last_part = !wide || (idx_q == 2'd3);

    // weight the product pair by its byte position
    always_comb begin
        partial = {16'h0000, bus.product_high_byte, bus.product_low_byte};
        unique case (idx_q)
            2'd0:    partial = partial << SHIFT_LL; // RULE6
            2'd1:    partial = partial << SHIFT_HH; // RULE6
            default: partial = partial << SHIFT_X;  // RULE6
        endcase
    end

    // sign corrections after the unsigned sum
    always_comb begin
        fixed = acc_q;
        if (mode_q == MODE_S8) begin
            if (b_q[7]) fixed[15:8] = fixed[15:8] - a_q[7:0]; // RULE5
            if (a_q[7]) fixed[15:8] = fixed[15:8] - b_q[7:0]; // RULE5
        end else if (mode_q == MODE_S16) begin
            if (b_q[15]) fixed[31:16] = fixed[31:16] - a_q; // RULE7
            if (a_q[15]) fixed[31:16] = fixed[31:16] - b_q; // RULE7
        end
    end

    // ==========================================================
    // control and datapath of the sequence
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= S_IDLE;
            idx_q   <= 2'd0;
            a_q     <= 16'h0000;
            b_q     <= 16'h0000;
            mode_q  <= MODE_U8;
            acc_q   <= 32'h0000_0000;
            op_q    <= OP_NOP;
            addr_q  <= 4'h0;
            wdata_q <= 8'h00;
            done    <= 1'b0;
            busy    <= 1'b0;
            wide_result_bytes <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            op_q <= OP_NOP;
            unique case (state_q)
                S_IDLE: begin
                    if (start) begin
                        a_q     <= operand_a;
                        b_q     <= operand_b;
                        mode_q  <= bhm_mode_t'(mode);
                        acc_q   <= 32'h0000_0000;
                        idx_q   <= 2'd0;
                        busy    <= 1'b1;
                        state_q <= S_FILE;
                    end
                end
                S_FILE: begin
                    // park the b bytes in file slots for the multiply
                    op_q    <= OP_WRF;
                    addr_q  <= idx_q[0] ? SLOT_B_HI : SLOT_B_LO;
                    wdata_q <= idx_q[0] ? b_q[15:8] : b_q[7:0];
                    idx_q   <= idx_q + 2'd1;
                    if (idx_q[0]) begin
                        idx_q   <= 2'd0;
                        state_q <= S_LDW;
                    end
                end
                S_LDW: begin
                    op_q    <= OP_LDW; // RULE4
                    wdata_q <= a_hi_sel ? a_q[15:8] : a_q[7:0];
                    state_q <= S_MUL;
                end
                S_MUL: begin
                    op_q    <= OP_MUL; // RULE4
                    addr_q  <= b_hi_sel ? SLOT_B_HI : SLOT_B_LO;
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    // spare slot: run the operand pair through the adder, so
                    // w and the flags show a byte sum or difference afterwards
                    op_q    <= idx_q[0] ? OP_SUB : OP_ADD;
                    state_q <= S_ACC;
                end
                S_ACC: begin
                    acc_q <= acc_q + partial; // RULE6
                    if (last_part) begin
                        state_q <= S_FIX;
                    end else begin
                        idx_q   <= idx_q + 2'd1;
                        state_q <= S_LDW;
                    end
                end
                S_FIX: begin
                    wide_result_bytes <= fixed; // RULE5 RULE7
                    // signed byte mode also leaves the corrected high byte
                    // in the product pair, as a software routine would
                    if (mode_q == MODE_S8) begin
                        op_q    <= OP_WPH; // RULE5
                        wdata_q <= fixed[15:8]; // RULE5
                    end
                    done    <= 1'b1;
                    busy    <= 1'b0;
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // requests to the core come straight from flops
    assign bus.op    = op_q;
    assign bus.addr  = addr_q;
    assign bus.wdata = wdata_q;

endmodule : bhm_seq

`default_nettype wire

//--- rtl/bhm_pkg.sv
package bhm_pkg;

    // ==========================================================
    // widths
    localparam int BYTE_W   = 8;
    localparam int PROD_W   = 16;
    localparam int WIDE_W   = 32;
    localparam int ADDR_W   = 4;
    localparam int FILE_N   = 16;
    localparam int FLAG_W   = 4;

    // ==========================================================
    // status flag positions
    localparam int FLAG_C   = 0;
    localparam int FLAG_Z   = 1;
    localparam int FLAG_OV  = 2;
    localparam int FLAG_N   = 3;

    // ==========================================================
    // values after reset
    localparam logic [7:0] WORKING_REGISTER_RST  = 8'h00;
    localparam logic [7:0] FILE_RST  = 8'h00;
    localparam logic [7:0] PROD_RST  = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;

    // ==========================================================
    // file slots for the multiply sequencer; it uses only the b slots
    localparam logic [3:0] SLOT_A_LO = 4'h0;
    localparam logic [3:0] SLOT_A_HI = 4'h1;
    localparam logic [3:0] SLOT_B_LO = 4'h2;
    localparam logic [3:0] SLOT_B_HI = 4'h3;

    // partial product weights, as shift counts
    localparam int SHIFT_HH = 16;
    localparam int SHIFT_X  = 8;
    localparam int SHIFT_LL = 0;

    // ==========================================================
    // core operations issued by the sequencer, all but OP_WPL
    typedef enum logic [2:0] {
        OP_NOP = 3'h0,  // idle
        OP_LDW = 3'h1,  // working_register <= data
        OP_WRF = 3'h2,  // file[addr] <= data
        OP_MUL = 3'h3,  // multiply_working_by_file
        OP_ADD = 3'h4,  // working_register += file[addr], flags
        OP_SUB = 3'h5,  // working_register -= file[addr], flags
        OP_WPH = 3'h6,  // explicit write of product_high_byte
        OP_WPL = 3'h7   // explicit write of product_low_byte
    } bhm_op_t;

    // multiply modes of the sequencer
    typedef enum logic [1:0] {
        MODE_U8  = 2'h0,
        MODE_S8  = 2'h1,
        MODE_U16 = 2'h2,
        MODE_S16 = 2'h3
    } bhm_mode_t;

endpackage : bhm_pkg

//--- rtl/bhm_if.sv
`timescale 1ns/1ps
`default_nettype none

interface bhm_if;
    import bhm_pkg::*;

    // ==========================================================
    // operation request, sequencer to core
    bhm_op_t          op;
    logic [3:0]       addr;
    logic [7:0]       wdata;

    // product register pair, core to sequencer
    logic [7:0]       product_high_byte;
    logic [7:0]       product_low_byte;

    modport core (
        input  op,
        input  addr,
        input  wdata,
        output product_high_byte,
        output product_low_byte
    );

    modport seq (
        output op,
        output addr,
        output wdata,
        input  product_high_byte,
        input  product_low_byte
    );

endinterface : bhm_if

`default_nettype wire

//--- rtl/bhm_core.sv
// Summary of operation
// RULE1: unsigned 8x8 product into high/low bytes
// RULE2: multiply leaves every status flag unchanged
// RULE3: product ready for the very next instruction
// RULE4: operands are working register and file register
// RULE5: signed 8x8 fixed by msb-driven subtractions
// RULE6: 16x16 is weighted sum of four partials
// RULE7: signed 16x16 subtracts other operand from top
// RULE8: product bytes hold until multiply or write
`timescale 1ns/1ps
`default_nettype none

module bhm_core
    import bhm_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,

    // operation port towards the sequencer
    bhm_if.core              bus,

    // user-side observation
    output var  logic [7:0]  working_register,
    output var  logic [3:0]  status_flags
);

    // ==========================================================
    // arithmetic helpers

    // flags of an 8-bit add or subtract; sub uses two's complement
    function automatic logic [3:0] alu_flags(
        input logic [7:0] x,
        input logic [7:0] y,
        input logic       sub
    );
        logic [7:0] yy;
        logic [8:0] sum;
        logic [3:0] f;
        yy        = sub ? ~y : y;
        sum       = {1'b0, x} + {1'b0, yy} + {8'h00, sub};
        f         = 4'h0;
        f[FLAG_C]  = sum[8];
        f[FLAG_Z]  = (sum[7:0] == 8'h00);
        f[FLAG_OV] = (x[7] == yy[7]) && (sum[7] != x[7]);
        f[FLAG_N]  = sum[7];
        return f;
    endfunction

    // 8-bit result of the same add or subtract
    // kept apart from alu_flags so each stays one plain expression
    function automatic logic [7:0] alu_sum(
        input logic [7:0] x,
        input logic [7:0] y,
        input logic       sub
    );
        logic [7:0] r;
        r = sub ? (x - y) : (x + y);
        return r;
    endfunction

    // unsigned byte product; 16 bits always hold it, so nothing is cut
    function automatic logic [15:0] mul_u8(
        input logic [7:0] x,
        input logic [7:0] y
    );
        return 16'(x) * 16'(y);
    endfunction

    // ==========================================================
    // state

    logic [7:0]  working_register_q;
    // the bank is small, so plain flops beat a memory macro here
    logic [7:0]  file_q [FILE_N];
    logic [7:0]  prod_hi_q;
    logic [7:0]  prod_lo_q;
    logic [3:0]  flags_q;

    // operand fetched from the file bank this cycle
    logic [7:0]  file_rd;
    // full unsigned product of the two operands
    logic [15:0] mul_full;
    // decoded request; each process reads only what it needs
    logic        is_ldw;
    logic        is_wrf;
    // is this an arithmetic op that touches the flags
    logic        is_arith;
    logic        is_sub;

    // ==========================================================
    // combinational datapath

    // the file operand is read straight from the addressed slot;
    // a write lands only at the edge, so a request in the same cycle
    // still reads the byte that was there before
    assign file_rd  = file_q[bus.addr]; // RULE4

    // single-cycle array multiply; both operands unsigned
    assign mul_full = mul_u8(working_register_q, file_rd); // RULE1

    // request decode, read by the register processes
    assign is_ldw   = (bus.op == OP_LDW);
    assign is_wrf   = (bus.op == OP_WRF);
    assign is_arith = (bus.op == OP_ADD) || (bus.op == OP_SUB);
    assign is_sub   = (bus.op == OP_SUB);

    // ==========================================================
    // working register

    // loaded by literal or replaced by add/sub result
    // a multiply never writes here, so one operand serves many multiplies
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            working_register_q <= WORKING_REGISTER_RST;
        end else if (is_ldw) begin
            working_register_q <= bus.wdata;
        end else if (is_arith) begin
            working_register_q <= alu_sum(working_register_q, file_rd, is_sub);
        end
    end

    // ==========================================================
    // file register bank

    // written whole bytes only; reset clears every slot
    // the sequencer parks the b operand bytes here once, before the first multiply
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < FILE_N; i++) begin
                file_q[i] <= FILE_RST;
            end
        end else if (is_wrf) begin
            file_q[bus.addr] <= bus.wdata;
        end
    end

    // ==========================================================
    // product register pair

    // a multiply replaces both bytes at once; the explicit writes touch
    // one byte each, so a saved pair is restored in two requests
    // upper byte: multiply result or explicit write, else hold
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prod_hi_q <= PROD_RST;
        end else begin
            unique case (bus.op)
                OP_MUL: begin
                    prod_hi_q <= mul_full[15:8]; // RULE1 RULE3
                end
                OP_WPH: begin
                    prod_hi_q <= bus.wdata; // RULE8
                end
                default: begin
                    prod_hi_q <= prod_hi_q; // RULE8
                end
            endcase
        end
    end

    // lower byte: same sources as the upper byte
    // (its own explicit write only; a high byte write leaves it alone)
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prod_lo_q <= PROD_RST;
        end else begin
            unique case (bus.op)
                OP_MUL: begin
                    prod_lo_q <= mul_full[7:0]; // RULE1 RULE3
                end
                OP_WPL: begin
                    prod_lo_q <= bus.wdata; // RULE8
                end
                default: begin
                    prod_lo_q <= prod_lo_q; // RULE8
                end
            endcase
        end
    end

    // ==========================================================
    // status flags

    // only add/sub update them; a multiply is deliberately absent
    // so software can multiply between a compare and its branch
    // a flag is never cleared by itself; only the next add or sub moves it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= FLAGS_RST;
        end else if (is_arith) begin
            flags_q <= alu_flags(working_register_q, file_rd, is_sub);
        end else begin
            flags_q <= flags_q; // RULE2
        end
    end

    // ==========================================================
    // outputs, all straight from flops

    // no gates between the flops and the ports, so nothing glitches out
    // product visible one edge after the multiply is taken
    assign bus.product_high_byte = prod_hi_q; // RULE3
    assign bus.product_low_byte  = prod_lo_q; // RULE3

    assign working_register = working_register_q;
    assign status_flags     = flags_q;

endmodule : bhm_core

`default_nettype wire

//--- verif/bhm_props.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// checker on the core-sequencer interface
module bhm_props
    import bhm_pkg::*;
(
    // clock and reset
    input wire logic       clk,
    input wire logic       arst_n,
    // interface signals
    input wire bhm_op_t    op,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] product_high_byte,
    input wire logic [7:0] product_low_byte,
    // core observation
    input wire logic [7:0] working_register,
    input wire logic [3:0] status_flags
);
    logic [7:0]  w_q;
    logic [7:0]  file_q [16];
    logic [15:0] mul_exp;
    logic [15:0] prod;
    logic [7:0]  file_rd_s;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // expected product from shadow state
    assign prod      = {product_high_byte, product_low_byte};
    assign file_rd_s = file_q[addr];
    assign mul_exp   = {8'h00, w_q} * {8'h00, file_rd_s};

    // shadow of w, so a stale operand is caught
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) w_q <= 8'h00;
        else if (op == OP_LDW) w_q <= wdata;
        else if (op == OP_ADD) w_q <= w_q + file_q[addr];
        else if (op == OP_SUB) w_q <= w_q - file_q[addr];
    end

    // shadow of the file bank
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) file_q[i] <= 8'h00;
        end else if (op == OP_WRF) begin
            file_q[addr] <= wdata;
        end
    end

    // ==========================================================
    // properties
    mul_product_a: assert property (op == OP_MUL |=> prod == $past(mul_exp))
        else $error("product is not w times file byte");
    mul_flags_a: assert property (op == OP_MUL |=> $stable(status_flags))
        else $error("multiply changed the flags");
    flags_alu_only_a: assert property (!(op inside {OP_ADD, OP_SUB}) |=>
        $stable(status_flags))
        else $error("flags moved without an add or subtract");
    mul_keeps_w_a: assert property (op == OP_MUL |=> $stable(working_register))
        else $error("multiply changed w");
    w_shadow_a: assert property (working_register == w_q)
        else $error("w differs from its shadow");
    w_load_a: assert property (op == OP_LDW |=> working_register == $past(wdata))
        else $error("w not loaded from literal");
    prod_hold_a: assert property (!(op inside {OP_MUL, OP_WPH, OP_WPL}) |=> $stable(prod))
        else $error("product moved without multiply or write");
    ldw_then_mul_a: assert property (op == OP_LDW ##1 op == OP_MUL |=>
        prod == {8'h00, $past(wdata, 2)} * {8'h00, $past(file_rd_s)})
        else $error("multiply did not use the byte just loaded");
    wph_write_a: assert property (op == OP_WPH |=>
        product_high_byte == $past(wdata) && $stable(product_low_byte))
        else $error("explicit high byte write went wrong");
endmodule // bhm_props

`default_nettype wire

//--- verif/byte_hardware_multiplier_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// bench: both ends joined, user side of sequencer driven
module byte_hardware_multiplier_tb_top
    import bhm_pkg::*;
;
    logic        clk;
    logic        arst_n;
    logic        start;
    logic [1:0]  mode;
    logic [15:0] operand_a;
    logic [15:0] operand_b;
    logic        busy;
    logic        done;
    logic [31:0] wide_result_bytes;
    logic [7:0]  working_register;
    logic [3:0]  status_flags;
    int          num_errors;
    int          checks_done;

    bhm_if u_bhm_if ();

    bhm_core u_bhm_core (
        .clk              (clk),
        .arst_n           (arst_n),
        .bus              (u_bhm_if.core),
        .working_register (working_register),
        .status_flags     (status_flags)
    );

    bhm_seq u_bhm_seq (
        .clk               (clk),
        .arst_n            (arst_n),
        .bus               (u_bhm_if.seq),
        .start             (start),
        .mode              (mode),
        .operand_a         (operand_a),
        .operand_b         (operand_b),
        .busy              (busy),
        .done              (done),
        .wide_result_bytes (wide_result_bytes)
    );

    bhm_props u_bhm_props (
        .clk               (clk),
        .arst_n            (arst_n),
        .op                (u_bhm_if.op),
        .addr              (u_bhm_if.addr),
        .wdata             (u_bhm_if.wdata),
        .product_high_byte (u_bhm_if.product_high_byte),
        .product_low_byte  (u_bhm_if.product_low_byte),
        .working_register  (working_register),
        .status_flags      (status_flags)
    );

    // ==========================================================
    // helpers
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // reference; 8-bit signed kept to 16 bits, not sign extended
    function automatic logic [31:0] mul_ref(input logic [1:0] m, input logic [15:0] a,
                                            input logic [15:0] b);
        logic signed [31:0] s;
        s = 0;
        case (m)
            2'h0: mul_ref = a[7:0] * b[7:0];
            2'h1: begin
                s = $signed(a[7:0]) * $signed(b[7:0]);
                mul_ref = {16'h0000, s[15:0]};
            end
            2'h2: mul_ref = a * b;
            default: mul_ref = $signed(a) * $signed(b);
        endcase
    endfunction

    // byte add or subtract as the adder must give it: {n, ov, z, c, result}
    function automatic logic [11:0] alu_ref(input logic [7:0] x, input logic [7:0] y,
                                            input logic sub);
        logic [8:0] s;
        logic       ov;
        s  = sub ? ({1'b0, x} - {1'b0, y}) : ({1'b0, x} + {1'b0, y});
        ov = sub ? (x[7] != y[7]) && (s[7] != x[7]) : (x[7] == y[7]) && (s[7] != x[7]);
        return {s[7], ov, (s[7:0] == 8'h00), (sub ? !s[8] : s[8]), s[7:0]};
    endfunction

    // bounded wait for done, counting edges
    task automatic wait_done(output int n);
        n = 0;
        while (n < 40 && done !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            chk32(32'h0, 32'h1);
            report_and_stop();
        end
    endtask

    task automatic run_mul(input logic [1:0] m, input logic [15:0] a, input logic [15:0] b,
                           input int lat);
        int          n;
        logic [31:0] full;
        logic [15:0] pair;
        logic [11:0] fw;
        full = mul_ref(m, a, b);
        // wide modes end on the a_hi * b_lo partial, byte modes on the result
        pair = m[1] ? {8'h00, a[15:8]} * {8'h00, b[7:0]} : full[15:0];
        // spare slot adds in byte modes, subtracts on the last wide partial
        fw = alu_ref(m[1] ? a[15:8] : a[7:0], b[7:0], m[1]);
        @(negedge clk);
        mode = m;
        operand_a = a;
        operand_b = b;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        wait_done(n);
        chk32(n, lat);
        chk32(wide_result_bytes, full);
        chk32({status_flags, working_register}, fw);
        @(posedge clk);
        #1;
        chk32(done, 1'b0);
        chk32({u_bhm_if.product_high_byte, u_bhm_if.product_low_byte}, pair);
    endtask

    // ==========================================================
    // scenarios
    task automatic sc_unsigned8();
        run_mul(2'h0, 16'h00ff, 16'h00ff, 7);
        run_mul(2'h0, 16'h12ff, 16'hab02, 7);
        run_mul(2'h0, 16'h0000, 16'h00a5, 7);
    endtask

    task automatic sc_signed8();
        run_mul(2'h1, 16'h0080, 16'h0080, 7);
        run_mul(2'h1, 16'h00ff, 16'h0001, 7);
        run_mul(2'h1, 16'h007f, 16'h0081, 7);
    endtask

    task automatic sc_unsigned16();
        run_mul(2'h2, 16'hffff, 16'hffff, 19);
        run_mul(2'h2, 16'h1234, 16'h5678, 19);
    endtask

    task automatic sc_signed16();
        run_mul(2'h3, 16'h8000, 16'h8000, 19);
        run_mul(2'h3, 16'hffff, 16'h0002, 19);
        run_mul(2'h3, 16'h7fff, 16'h8001, 19);
    endtask

    // start while busy must not replace the operands
    task automatic sc_busy_refuse();
        int n;
        @(negedge clk);
        mode = 2'h0;
        operand_a = 16'h0003;
        operand_b = 16'h0005;
        start = 1'b1;
        @(negedge clk);
        operand_a = 16'h0007;
        operand_b = 16'h0009;
        repeat (3) @(negedge clk);
        start = 1'b0;
        wait_done(n);
        chk32(wide_result_bytes, 32'h0000000f);
        run_mul(2'h0, 16'h0007, 16'h0009, 7);
    endtask

    // reset mid-sequence, then the result must hold while idle
    task automatic sc_reset_hold();
        @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (2) @(negedge clk);
        arst_n = 1'b0;
        #1;
        chk32({busy, done}, 2'h0);
        chk32(wide_result_bytes, 32'h0);
        @(negedge clk);
        arst_n = 1'b1;
        run_mul(2'h2, 16'hbeef, 16'h0102, 19);
        repeat (10) @(posedge clk);
        #1;
        chk32(wide_result_bytes, mul_ref(2'h2, 16'hbeef, 16'h0102));
    endtask

    // ==========================================================
    // main sequence
    initial begin
        num_errors = 0;
        checks_done = 0;
        arst_n = 1'b0;
        start = 1'b0;
        mode = 2'h0;
        operand_a = 16'h0000;
        operand_b = 16'h0000;
        repeat (12) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        sc_unsigned8();
        sc_signed8();
        sc_unsigned16();
        sc_signed16();
        sc_busy_refuse();
        sc_reset_hold();
        report_and_stop();
    end
endmodule // byte_hardware_multiplier_tb_top

`default_nettype wire
